// ==== rtl/aps_defs.svh ====
/*
 * constants for the power ramp index block: widths, reset values, step rate.
 * assumes inclusion by bare name from rtl files.
 */
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH
`define APS_STEPS_PER_SYMBOL 8
`define APS_INDEX_W 3
`define APS_TABLE_DEPTH 8
`define APS_LEVEL_W 8
`define APS_INDEX_RST 3'h0
`define APS_LEVEL_RST 8'h00
`define APS_DIV_W 16
`endif

// ==== rtl/aps_pkg.sv ====
/*
 * types for the power ramp index block.
 * assumes aps_defs.svh on the include path.
 */
`include "aps_defs.svh"
package aps_pkg;
    typedef logic [`APS_INDEX_W-1:0] aps_index_t;
    typedef logic [`APS_LEVEL_W-1:0] aps_level_t;
    typedef enum logic [1:0]
    {
        APS_IDLE = 2'b00,
        APS_RUN = 2'b01,
        APS_DRAIN = 2'b10
    } aps_state_t;
endpackage : aps_pkg

// ==== rtl/aps_step_tick.sv ====
/*
 * step tick generator: one pulse every div+1 clocks while enabled.
 * assumes div from the same clock domain.
 */
`timescale 1ns/1ps
`include "aps_defs.svh"
module aps_step_tick
(
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic [`APS_DIV_W-1:0] div,
    output logic tick
);
    logic [`APS_DIV_W-1:0] cnt_r;
    logic [`APS_DIV_W-1:0] cnt_nxt;
    logic tick_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!run)
        begin
            cnt_nxt = '0;
        end
        else if (cnt_r >= div)
        begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule : aps_step_tick

// ==== rtl/aps_ramp_index.sv ====
/*
 * power ramp / ask shaping index generator with power level table.
 * assumes all inputs except tx_symbol and tx_active on this clock; tx_symbol and tx_active
 * come from a pin and are synchronised here.
 */
`timescale 1ns/1ps
`include "aps_defs.svh"

module aps_ramp_index
    import aps_pkg::*;
#(
    parameter int STEPS = `APS_STEPS_PER_SYMBOL,
    parameter int DEPTH = `APS_TABLE_DEPTH
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic tx_active,
    input wire logic tx_symbol,
    input wire logic [`APS_DIV_W-1:0] step_div,
    input wire logic [`APS_INDEX_W-1:0] upper_power_index,
    input wire logic table_wr,
    input wire logic [`APS_INDEX_W-1:0] table_addr,
    input wire logic [`APS_LEVEL_W-1:0] table_data,
    output logic [`APS_LEVEL_W-1:0] pa_level,
    output logic [`APS_INDEX_W-1:0] power_index,
    output logic tx_busy
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic act_s1_r;
    logic act_s2_r;
    logic sym_s1_r;
    logic sym_s2_r;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            act_s1_r <= 1'b0;
            act_s2_r <= 1'b0;
            sym_s1_r <= 1'b0;
            sym_s2_r <= 1'b0;
        end
        else
        begin
            act_s1_r <= tx_active;
            act_s2_r <= act_s1_r;
            sym_s1_r <= tx_symbol;
            sym_s2_r <= sym_s1_r;
        end
    end

    // ----------------------------------------
    // power level table
    // ----------------------------------------
    aps_level_t power_level_table [DEPTH];
    aps_level_t tbl_nxt [DEPTH];

    generate
        for (genvar g = 0; g < DEPTH; g++)
        begin : g_tbl
            always_comb
            begin
                tbl_nxt[g] = power_level_table[g];
                if (table_wr && (int'(table_addr) == g))
                begin
                    tbl_nxt[g] = table_data;
                end
            end

            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    power_level_table[g] <= `APS_LEVEL_RST;
                end
                else
                begin
                    power_level_table[g] <= tbl_nxt[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // step tick
    // ----------------------------------------
    aps_state_t state_r;
    aps_state_t state_nxt;
    logic tick;
    logic tick_run;

    // divider only counts outside idle
    always_comb
    begin
        tick_run = (state_r != APS_IDLE);
    end

    // step_div set for eight ticks per symbol
    // tick period is step_div+1 clocks
    aps_step_tick aps_step_tick_inst
    (
        .clock(clock),
        .rst(rst),
        .run(tick_run),
        .div(step_div),
        .tick(tick)
    );

    // ----------------------------------------
    // shaping counter and sequencing
    // ----------------------------------------
    aps_index_t idx_r;
    aps_index_t idx_nxt;
    aps_level_t level_nxt;
    logic busy_nxt;

    always_comb
    begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        case (state_r)
            APS_IDLE:
            begin
                idx_nxt = `APS_INDEX_RST;
                if (act_s2_r)
                begin
                    state_nxt = APS_RUN;
                end
            end
            APS_RUN:
            begin
                if (!act_s2_r)
                begin
                    state_nxt = APS_DRAIN;
                end
                else if (tick)
                begin
                    // up on one, down on zero
                    if (sym_s2_r)
                    begin
                        if (idx_r < upper_power_index)
                        begin
                            idx_nxt = idx_r + 3'h1;
                        end
                        else
                        begin
                            // a lowered ceiling clamps here
                            idx_nxt = upper_power_index;
                        end
                    end
                    else if (idx_r != 3'h0)
                    begin
                        idx_nxt = idx_r - 3'h1;
                    end
                end
            end
            APS_DRAIN:
            begin
                if (act_s2_r)
                begin
                    state_nxt = APS_RUN;
                end
                else if (idx_r == 3'h0)
                begin
                    state_nxt = APS_IDLE;
                end
                else if (tick)
                begin
                    idx_nxt = idx_r - 3'h1;
                end
            end
            default:
            begin
                state_nxt = APS_IDLE;
                idx_nxt = `APS_INDEX_RST;
            end
        endcase
        level_nxt = power_level_table[idx_nxt];
        busy_nxt = (state_nxt != APS_IDLE);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= APS_IDLE;
            idx_r <= `APS_INDEX_RST;
            pa_level <= `APS_LEVEL_RST;
            power_index <= `APS_INDEX_RST;
            tx_busy <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            pa_level <= level_nxt;
            power_index <= idx_nxt;
            tx_busy <= busy_nxt;
        end
    end
endmodule : aps_ramp_index

// ==== dv/aps_ramp_chk.sv ====
/* checker for the ramp index: steps, limits, idle.
   assumes bind onto aps_ramp_index, one clock. */
`timescale 1ns/1ps
`include "aps_defs.svh"
module aps_ramp_chk
(
    input wire logic clock,
    input wire logic rst,
    input wire logic tx_active,
    input wire logic [`APS_DIV_W-1:0] step_div,
    input wire logic [`APS_INDEX_W-1:0] upper_power_index,
    input wire logic [`APS_INDEX_W-1:0] power_index,
    input wire logic tx_busy
);
    // ----
    // properties
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_start;
        $rose(tx_active) ##1 tx_active;
    endsequence
    property p_start;
        s_start |-> ##[1:3] tx_busy;
    endproperty
    a_start: assert property (p_start) else $error("busy late");
    property p_up_one;
        power_index > $past(power_index) |-> power_index == $past(power_index) + 3'h1;
    endproperty
    a_up_one: assert property (p_up_one) else $error("index jump");
    property p_ceil;
        power_index > $past(power_index) |-> power_index <= upper_power_index;
    endproperty
    a_ceil: assert property (p_ceil) else $error("over ceiling");
    property p_gap;
        (step_div != 16'h0000 && $changed(power_index)) |=> $stable(power_index);
    endproperty
    a_gap: assert property (p_gap) else $error("step too soon");
    property p_idle;
        !tx_busy |-> power_index == 3'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle index");
    property p_end;
        $fell(tx_busy) |-> $past(power_index) == 3'h0;
    endproperty
    a_end: assert property (p_end) else $error("end not at zero");
endmodule : aps_ramp_chk
bind aps_ramp_index aps_ramp_chk aps_ramp_chk_inst (.clock(clock), .rst(rst), .tx_active(tx_active),
    .step_div(step_div), .upper_power_index(upper_power_index), .power_index(power_index), .tx_busy(tx_busy));

// ==== dv/aps_sym_src.sv ====
/* symbol source: eight symbols a frame, msb first.
   assumes bits held while a frame runs. */
`timescale 1ns/1ps
module aps_sym_src
#(
    parameter int SYM = 16
)
(
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] bits,
    output logic tx_active,
    output logic tx_symbol
);
    initial
    begin
        tx_active = 1'b0;
        tx_symbol = 1'b0;
        forever
        begin
            @(posedge go);
            for (int i = 7; i >= 0; i--)
            begin
                tx_active = 1'b1;
                tx_symbol = bits[i];
                repeat (SYM) @(posedge clock);
                #1;
            end
            tx_active = 1'b0;
            // symbol line carries no meaning outside a frame
            tx_symbol = ~tx_symbol;
        end
    end
endmodule : aps_sym_src

// ==== dv/aps_ramp_index_tb_top.sv ====
/* bench for the ramp index block.
   assumes aps_sym_src drives the symbol pins. */
`timescale 1ns/1ps
module aps_ramp_index_tb_top;
    logic clock = 0, rst = 1, go = 0, table_wr = 0;
    logic [2:0] upper_power_index = 3'h7, table_addr = 3'h0, power_index;
    logic [7:0] table_data = 8'h00, bits = 8'h00, pa_level;
    logic tx_busy, tx_active, tx_symbol;
    int mismatches = 0, n_checks = 0;
    always #50 clock = ~clock;
    aps_sym_src aps_sym_src_inst (.clock(clock), .go(go), .bits(bits), .tx_active(tx_active), .tx_symbol(tx_symbol));
    aps_ramp_index aps_ramp_index_inst (.clock(clock), .rst(rst), .tx_active(tx_active), .tx_symbol(tx_symbol),
        .step_div(16'h0001), .upper_power_index(upper_power_index), .table_wr(table_wr), .table_addr(table_addr),
        .table_data(table_data), .pa_level(pa_level), .power_index(power_index), .tx_busy(tx_busy));
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task step;
        @(posedge clock);
        #1;
    endtask : step
    task wr(input logic [2:0] a, input logic [7:0] d);
        table_wr = 1;
        table_addr = a;
        table_data = d;
        step;
        table_wr = 0;
        step;
    endtask : wr
    // wait until the chosen flag equals v, returns cycles taken
    task wt(input bit act, input logic v, output int n);
        n = 0;
        while ((act ? tx_active : tx_busy) !== v)
        begin
            step;
            n++;
            if (n > 400)
            begin
                mismatches++;
                print_verdict;
            end
        end
    endtask : wt
    task send(input logic [7:0] b);
        bits = b;
        go = 1;
        step;
        go = 0;
    endtask : send
    task t_ramp;
        int n;
        upper_power_index = 3'h7;
        send(8'hff);
        wt(0, 1, n);
        n = 0;
        while (power_index !== 3'h7 && n < 100)
        begin
            step;
            n++;
        end
        chk("ramp cycles", 8'h0f, 8'(n));
        chk("top level", 8'h37, pa_level);
        wt(1, 0, n);
        chk("held top", 8'h07, 8'(power_index));
        wt(0, 0, n);
        chk("end level", 8'h00, pa_level);
        $display("ramp done");
    endtask : t_ramp
    task t_ask;
        int n;
        send(8'hf0);
        wt(1, 1, n);
        wt(1, 0, n);
        chk("floor idx", 8'h00, 8'(power_index));
        chk("still busy", 8'h01, 8'(tx_busy));
        wt(0, 0, n);
        $display("ask done");
    endtask : t_ask
    task t_flat;
        int n;
        upper_power_index = 3'h0;
        wr(3'h0, 8'h3f);
        send(8'hff);
        wt(0, 1, n);
        n = 0;
        while (tx_active === 1'b1)
        begin
            chk("flat level", 8'h3f, pa_level);
            step;
            n++;
            if (n > 400)
            begin
                mismatches++;
                print_verdict;
            end
        end
        wt(0, 0, n);
        $display("flat done");
    endtask : t_flat
    task t_ook;
        int n;
        int hi;
        int bad;
        hi = 0;
        bad = 0;
        upper_power_index = 3'h1;
        wr(3'h0, 8'h00);
        send(8'haa);
        wt(0, 1, n);
        n = 0;
        while (tx_active === 1'b1)
        begin
            if (pa_level === 8'h31)
                hi++;
            else if (pa_level !== 8'h00)
                bad++;
            step;
            n++;
            if (n > 400)
            begin
                mismatches++;
                print_verdict;
            end
        end
        chk("ook high cycles", 8'h3e, 8'(hi));
        chk("ook other level", 8'h00, 8'(bad));
        wt(0, 0, n);
        $display("ook done");
    endtask : t_ook
    initial
    begin
        repeat (8) @(posedge clock);
        #1;
        rst = 0;
        for (int k = 1; k < 8; k++)
            wr(3'(k), 8'h30 + 8'(k));
        t_ramp;
        t_ask;
        t_flat;
        t_ook;
        print_verdict;
    end
endmodule : aps_ramp_index_tb_top
